// ### logic/rpp_port_status.sv
// Port paging and per-port receiver status registers.
`timescale 1ns/10ps
module rpp_port_status
  import rpp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic acc_valid,
  input wire rpp_access_type acc,
  input wire logic [RPP_PORTS-1:0] receiver_locked,
  input wire logic [RPP_PORTS-1:0] port_pass,
  input wire rpp_events_type events,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [1:0] cur_read_port,
  output logic [RPP_PORTS-1:0] cur_write_enable
);

  logic [1:0] read_port_reg [RPP_SOURCES];
  logic [RPP_PORTS-1:0] write_en_reg [RPP_SOURCES];
  logic [RPP_PORTS-1:0] lock_sync_reg;
  logic [RPP_PORTS-1:0] lock_prev_reg;
  logic [RPP_PORTS-1:0] lock_change;
  logic [RPP_PORTS-1:0] pass_sync_reg;
  logic [RPP_PORTS-1:0] checksum_reg;
  logic [RPP_PORTS-1:0] lock_chg_reg;
  logic [RPP_PORTS-1:0] sequence_reg;
  logic [RPP_PORTS-1:0] parity_reg;
  logic [RPP_PORTS-1:0] unsteady_reg;
  logic [RPP_PORTS-1:0] len_chg_reg;
  logic [RPP_PORTS-1:0] coding_reg;
  logic [RPP_PORTS-1:0] buffer_reg;
  logic rd_valid_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic [1:0] cur_read_port_reg;
  logic [RPP_PORTS-1:0] cur_write_enable_reg;
  logic [2:0] src;
  logic [1:0] sel;
  logic [1:0] link_num;
  logic rd_a;
  logic rd_b;
  logic [RPP_PORTS-1:0] clr_a;
  logic [RPP_PORTS-1:0] clr_b;

  // Source 0 is the local port, sources 1 to 4 are remote links 0 to 3.
  assign src = acc.remote ? {1'b0, acc.link} + 3'h1 : 3'h0;
  assign sel = read_port_reg[src];
  assign link_num = acc.remote ? acc.link : RPP_LOCAL_LINK_NUMBER;
  assign rd_a = acc_valid && !acc.write && acc.addr == RPP_STATUS_A_OFFSET;
  assign rd_b = acc_valid && !acc.write && acc.addr == RPP_STATUS_B_OFFSET;
  assign clr_a = rd_a ? (4'h1 << sel) : 4'h0;
  assign clr_b = rd_b ? (4'h1 << sel) : 4'h0;

  // Lock level from the receivers, two flip-flops deep.
  rpp_sync_stage #(
    .WIDTH(RPP_PORTS)
  ) u_lock_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(receiver_locked),
    .sync_out(lock_sync_reg)
  );

  // Pass level from the receivers, two flip-flops deep.
  rpp_sync_stage #(
    .WIDTH(RPP_PORTS)
  ) u_pass_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(port_pass),
    .sync_out(pass_sync_reg)
  );

  // Previous synchronised lock level for change detection.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_prev_reg <= '0;
    end else begin
      lock_prev_reg <= lock_sync_reg;
    end
  end

  assign lock_change = lock_sync_reg ^ lock_prev_reg;

  // Paging state kept per access source.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      read_port_reg[0] <= RPP_LOCAL_READ_PORT_RESET;
      write_en_reg[0] <= RPP_LOCAL_WRITE_EN_RESET;
      for (int i = 1; i < RPP_SOURCES; i++) begin
        read_port_reg[i] <= 2'(i - 1);
        write_en_reg[i] <= 4'(1 << (i - 1));
      end
    end else if (acc_valid && acc.write && acc.addr == RPP_PAGING_OFFSET) begin
      read_port_reg[src] <= acc.wdata[RPP_FIELD_READ_PORT_HI:RPP_FIELD_READ_PORT_LO];
      write_en_reg[src] <= acc.wdata[RPP_FIELD_WRITE_EN_HI:RPP_FIELD_WRITE_EN_LO];
    end
  end

  // Page and enables of the latest accessor, for the paged register blocks.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_read_port_reg <= RPP_LOCAL_READ_PORT_RESET;
      cur_write_enable_reg <= RPP_LOCAL_WRITE_EN_RESET;
    end else if (acc_valid) begin
      cur_read_port_reg <= sel;
      cur_write_enable_reg <= write_en_reg[src];
    end
  end

  rpp_sticky_flags #(
    .WIDTH(RPP_PORTS)
  ) u_checksum_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(events.checksum),
    .clr_in(clr_a),
    .flag_out(checksum_reg)
  );

  rpp_sticky_flags #(
    .WIDTH(RPP_PORTS)
  ) u_lock_chg_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(lock_change),
    .clr_in(clr_a),
    .flag_out(lock_chg_reg)
  );

  rpp_sticky_flags #(
    .WIDTH(RPP_PORTS)
  ) u_sequence_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(events.sequence_err),
    .clr_in(clr_a),
    .flag_out(sequence_reg)
  );

  rpp_sticky_flags #(
    .WIDTH(RPP_PORTS)
  ) u_parity_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(events.parity_over),
    .clr_in(events.parity_cleared),
    .flag_out(parity_reg)
  );

  rpp_sticky_flags #(
    .WIDTH(RPP_PORTS)
  ) u_unsteady_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(events.len_unsteady),
    .clr_in(clr_b),
    .flag_out(unsteady_reg)
  );

  rpp_sticky_flags #(
    .WIDTH(RPP_PORTS)
  ) u_len_chg_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(events.len_changed),
    .clr_in(clr_b),
    .flag_out(len_chg_reg)
  );

  rpp_sticky_flags #(
    .WIDTH(RPP_PORTS)
  ) u_coding_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(events.coding),
    .clr_in(clr_b),
    .flag_out(coding_reg)
  );

  rpp_sticky_flags #(
    .WIDTH(RPP_PORTS)
  ) u_buffer_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(events.buffer_overflow),
    .clr_in(clr_b),
    .flag_out(buffer_reg)
  );

  // Read multiplexer over the selected page.
  always_comb begin
    rd_data_next = RPP_UNMAPPED_READ;
    case (acc.addr)
      RPP_PAGING_OFFSET: begin
        rd_data_next[RPP_FIELD_PORT_HI:RPP_FIELD_PORT_LO] = link_num;
        rd_data_next[RPP_FIELD_READ_PORT_HI:RPP_FIELD_READ_PORT_LO] = sel;
        rd_data_next[RPP_FIELD_WRITE_EN_HI:RPP_FIELD_WRITE_EN_LO] = write_en_reg[src];
      end
      RPP_STATUS_A_OFFSET: begin
        rd_data_next = RPP_STATUS_A_RESET;
        rd_data_next[RPP_FIELD_PORT_HI:RPP_FIELD_PORT_LO] = sel;
        rd_data_next[RPP_A_CHECKSUM_BIT] = checksum_reg[sel];
        rd_data_next[RPP_A_LOCK_CHANGED_BIT] = lock_chg_reg[sel];
        rd_data_next[RPP_A_SEQUENCE_BIT] = sequence_reg[sel];
        rd_data_next[RPP_A_PARITY_BIT] = parity_reg[sel];
        rd_data_next[RPP_A_PASS_BIT] = pass_sync_reg[sel];
        rd_data_next[RPP_A_LOCKED_BIT] = lock_sync_reg[sel];
      end
      RPP_STATUS_B_OFFSET: begin
        rd_data_next = RPP_STATUS_B_RESET;
        rd_data_next[RPP_B_UNSTEADY_BIT] = unsteady_reg[sel];
        rd_data_next[RPP_B_LEN_CHANGED_BIT] = len_chg_reg[sel];
        rd_data_next[RPP_B_CODING_BIT] = coding_reg[sel];
        rd_data_next[RPP_B_BUFFER_BIT] = buffer_reg[sel];
      end
      default: begin
        rd_data_next = RPP_UNMAPPED_READ;
      end
    endcase
  end

  // Read answer one cycle after the access.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= RPP_UNMAPPED_READ;
    end else begin
      rd_valid_reg <= acc_valid && !acc.write;
      if (acc_valid && !acc.write) begin
        rd_data_reg <= rd_data_next;
      end
    end
  end

  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;
  assign cur_read_port = cur_read_port_reg;
  assign cur_write_enable = cur_write_enable_reg;

endmodule : rpp_port_status

// Two flip-flop synchroniser for levels from outside the clock domain.
module rpp_sync_stage #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Only the second stage leaves this module.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : rpp_sync_stage

// Per-port sticky flags; an event in the cycle of a clear keeps the flag.
module rpp_sticky_flags #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clr_in,
  output logic [WIDTH-1:0] flag_out
);

  logic [WIDTH-1:0] flag_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= (flag_reg & ~clr_in) | set_in;
    end
  end

  assign flag_out = flag_reg;

endmodule : rpp_sticky_flags

// ### shared/rpp_pkg.sv
// Package with register map, reset values and carrier types for port paging and status.
package rpp_pkg;

  localparam int RPP_PORTS = 4;
  localparam int RPP_SOURCES = 5;

  localparam logic [7:0] RPP_PAGING_OFFSET = 8'h4C;
  localparam logic [7:0] RPP_STATUS_A_OFFSET = 8'h4D;
  localparam logic [7:0] RPP_STATUS_B_OFFSET = 8'h4E;

  localparam logic [7:0] RPP_STATUS_A_RESET = 8'h00;
  localparam logic [7:0] RPP_STATUS_B_RESET = 8'h00;
  localparam logic [7:0] RPP_UNMAPPED_READ = 8'h00;
  localparam logic [1:0] RPP_LOCAL_READ_PORT_RESET = 2'h0;
  localparam logic [3:0] RPP_LOCAL_WRITE_EN_RESET = 4'h0;
  localparam logic [1:0] RPP_LOCAL_LINK_NUMBER = 2'h0;

  localparam int RPP_FIELD_PORT_HI = 7;
  localparam int RPP_FIELD_PORT_LO = 6;
  localparam int RPP_FIELD_READ_PORT_HI = 5;
  localparam int RPP_FIELD_READ_PORT_LO = 4;
  localparam int RPP_FIELD_WRITE_EN_HI = 3;
  localparam int RPP_FIELD_WRITE_EN_LO = 0;

  localparam int RPP_A_CHECKSUM_BIT = 5;
  localparam int RPP_A_LOCK_CHANGED_BIT = 4;
  localparam int RPP_A_SEQUENCE_BIT = 3;
  localparam int RPP_A_PARITY_BIT = 2;
  localparam int RPP_A_PASS_BIT = 1;
  localparam int RPP_A_LOCKED_BIT = 0;
  localparam int RPP_B_UNSTEADY_BIT = 7;
  localparam int RPP_B_LEN_CHANGED_BIT = 6;
  localparam int RPP_B_CODING_BIT = 5;
  localparam int RPP_B_BUFFER_BIT = 4;

  typedef struct packed {
    logic write;
    logic remote;
    logic [1:0] link;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpp_access_type;

  typedef struct packed {
    logic [RPP_PORTS-1:0] checksum;
    logic [RPP_PORTS-1:0] sequence_err;
    logic [RPP_PORTS-1:0] parity_over;
    logic [RPP_PORTS-1:0] parity_cleared;
    logic [RPP_PORTS-1:0] len_unsteady;
    logic [RPP_PORTS-1:0] len_changed;
    logic [RPP_PORTS-1:0] coding;
    logic [RPP_PORTS-1:0] buffer_overflow;
  } rpp_events_type;

endpackage : rpp_pkg

// ### tb/rpp_host_model.sv
// Host model that issues paged register accesses.
`timescale 1ns/10ps
module rpp_host_model
  import rpp_pkg::*;
(
  input wire logic clk,
  output logic acc_valid,
  output rpp_access_type acc
);
  initial acc_valid = 1'h0;
  initial acc = '0;
  // Holds one access over one edge, then leaves the inverse on the idle bus.
  task automatic xfer(input rpp_access_type a);
    acc_valid = 1'h1;
    acc = a;
    @(posedge clk);
    #1;
    acc_valid = 1'h0;
    acc = ~a;
  endtask : xfer
endmodule : rpp_host_model

// ### tb/rpp_port_status_assertions.sv
// Checker watching the port paging and status register ports.
`timescale 1ns/10ps
module rpp_port_status_assertions
  import rpp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic acc_valid,
  input wire rpp_access_type acc,
  input wire logic [RPP_PORTS-1:0] receiver_locked,
  input wire logic [RPP_PORTS-1:0] port_pass,
  input wire rpp_events_type events,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] cur_read_port,
  input wire logic [RPP_PORTS-1:0] cur_write_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire rd = acc_valid && !acc.write;
  wire rd_a = rd && acc.addr == 8'h4D;
  wire rd_p = rd && acc.addr == 8'h4C;
  read_answer_a:
    assert property (rd |=> rd_valid) else $error("read not answered");
  stray_answer_a:
    assert property (!rd |=> !rd_valid) else $error("stray answer");
  data_hold_a:
    assert property (!rd_valid |-> $stable(rd_data)) else $error("read data moved");
  port_field_a:
    assert property (rd_a |=> rd_data[7:6] == cur_read_port) else $error("bad port field");
  local_link_a:
    assert property (rd_p && !acc.remote |=> rd_data[7:6] == 2'h0) else $error("local link");
  remote_link_a:
    assert property (rd_p && acc.remote |=> rd_data[7:6] == $past(acc.link)) else $error("link");
  page_fields_a:
    assert property (rd_p |=> rd_data[5:0] == {cur_read_port, cur_write_enable})
      else $error("bad paging fields");
  checksum_flag_a:
    assert property (rd_a && events.checksum == 4'hF ##1 !acc_valid ##1 rd_a |=> rd_data[5])
      else $error("checksum flag lost");
  cover property (rd_a ##1 rd_data[5]);
  cover property (acc_valid && acc.write && acc.addr == 8'h4C);
  cover property (rd_p && acc.remote);
endmodule : rpp_port_status_assertions
bind rpp_port_status rpp_port_status_assertions u_chk (.clk, .sys_rst, .acc_valid, .acc,
  .receiver_locked, .port_pass, .events, .rd_valid, .rd_data, .cur_read_port, .cur_write_enable);

// ### tb/rpp_port_status_bench.sv
// Self-checking bench for port paging and status registers.
`timescale 1ns/10ps
module rpp_port_status_bench
  import rpp_pkg::*;
;
  typedef struct packed {rpp_access_type a; logic c; logic [7:0] e;} rpp_row_type;
  logic clk = 1'h0, sys_rst = 1'h1, acc_valid, rd_valid;
  logic [3:0] receiver_locked = 4'h5, port_pass = 4'h3;
  logic [7:0] rd_data;
  logic [1:0] cur_read_port;
  logic [3:0] cur_write_enable;
  rpp_access_type acc;
  rpp_events_type events = '0;
  int n_mismatch = 0, tests_run = 0, i;
  rpp_row_type rows [6];
  rpp_row_type hand;
  always #10 clk = ~clk;
  rpp_host_model u_host (.clk, .acc_valid, .acc);
  rpp_port_status u_dut (.clk, .sys_rst, .acc_valid, .acc, .receiver_locked, .port_pass,
    .events, .rd_valid, .rd_data, .cur_read_port, .cur_write_enable);
  function automatic rpp_row_type row(input logic [4:0] k, input logic [7:0] ad, wd, e);
    return {k[3:0], ad, wd, k[4], e};
  endfunction : row
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic end_sim();
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic check(input logic [7:0] seen, want);
    tests_run++;
    if (seen !== want) $display("wrong value at %0t: %h not %h", $time, seen, want);
    if (seen !== want) n_mismatch++;
  endtask : check
  task automatic run(input rpp_row_type r);
    u_host.xfer(r.a);
    for (i = 0; i < 4 && !r.a.write && rd_valid !== 1'h1; i++) tick(1);
    if (i == 4) begin
      n_mismatch++;
      end_sim();
    end else begin
      if (r.c) check(rd_data, r.e);
      // One idle edge so the strobe never changes twice in one step.
      tick(1);
    end
  endtask : run
  initial begin
    rows[0] = row(5'h10, 8'h4C, 8'h00, 8'h00);
    rows[1] = row(5'h08, 8'h4C, 8'hE5, 8'h00);
    rows[2] = row(5'h10, 8'h4C, 8'h00, 8'h25);
    rows[3] = row(5'h00, 8'h4D, 8'h00, 8'h00);
    rows[4] = row(5'h10, 8'h4D, 8'h00, 8'h81);
    rows[5] = row(5'h17, 8'h4C, 8'h00, 8'hF8);
    tick(10);
    sys_rst = 1'h0;
    foreach (rows[j]) run(rows[j]);
    run(row(5'h08, 8'h4C, 8'h10, 8'h00));
    // Pulse on every event input but parity_cleared, as from a configured counter.
    events = {12'hF22, 4'h0, 16'h2222};
    tick(1);
    events = '0;
    run(row(5'h10, 8'h4D, 8'h00, 8'h6E));
    run(row(5'h10, 8'h4E, 8'h00, 8'hF0));
    run(row(5'h10, 8'h4D, 8'h00, 8'h46));
    run(row(5'h10, 8'h4E, 8'h00, 8'h00));
    events.parity_cleared = 4'h2;
    tick(1);
    events = '0;
    run(row(5'h10, 8'h4D, 8'h00, 8'h42));
    receiver_locked = 4'h7;
    tick(4);
    run(row(5'h10, 8'h4D, 8'h00, 8'h53));
    run(row(5'h10, 8'h4D, 8'h00, 8'h43));
    events.checksum = 4'hF;
    hand = row(5'h00, 8'h4D, 8'h00, 8'h00);
    u_host.xfer(hand.a);
    events = '0;
    tick(1);
    run(row(5'h10, 8'h4D, 8'h00, 8'h63));
    run(row(5'h0D, 8'h4C, 8'h3F, 8'h00));
    run(row(5'h15, 8'h4C, 8'h00, 8'h7F));
    check({6'h00, cur_read_port}, 8'h03);
    check({4'h0, cur_write_enable}, 8'h0F);
    run(row(5'h10, 8'h4C, 8'h00, 8'h10));
    sys_rst = 1'h1;
    tick(2);
    sys_rst = 1'h0;
    run(row(5'h10, 8'h4C, 8'h00, 8'h00));
    run(row(5'h15, 8'h4C, 8'h00, 8'h52));
    end_sim();
  end
endmodule : rpp_port_status_bench
